// ---- src/mir_pkg.sv ----
// shared constants and types of the memory init and refresh link
package mir_pkg;
   // link widths
   localparam int BANK_W = 3;
   localparam int ADDR_W = 18;
   localparam int NUM_BANKS = 8;
   localparam int DQ_WIDTH_MAX = 36;
   // system clock
   localparam int CLK_PERIOD_PS = 8000;
   // power-up nop hold, least time, rounded up
   localparam int HOLD_TIME_US = 200;
   localparam int HOLD_CYCLES =
      (HOLD_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // average refresh interval, longest time, rounded down
   localparam int REFI_TIME_PS = 240000;
   localparam int REFI_CYCLES = REFI_TIME_PS / CLK_PERIOD_PS;
   // burst refresh period, longest time, rounded down
   localparam int BURST_TIME_PS = 1950000;
   localparam int BURST_CYCLES = BURST_TIME_PS / CLK_PERIOD_PS;
   // mode-register load recovery, in command clocks
   localparam int MRSC_CYCLES = 6;
   // initialization group and tail
   localparam int MIN_LOADS = 3;
   localparam int DUMMY_LOADS = 2;
   localparam int INIT_NOPS = 1024;
   // configuration field and reset value
   localparam int CFG_LSB = 0;
   localparam int CFG_W = 3;
   localparam logic [ADDR_W-1:0] MODE_RESET = 18'h00000;
   localparam logic [3:0] TRC_DEFAULT = 4'h4;

   typedef enum logic [2:0] {
      cmd_nop,
      cmd_mode_register_load,
      cmd_bank_refresh_cmd,
      cmd_read,
      cmd_write
   } mir_cmd_type;

   // row cycle time in clocks for a mode-register configuration
   function automatic logic [3:0] row_cycle_time(
      input logic [ADDR_W-1:0] mode);
      case (mode[CFG_LSB +: CFG_W])
         3'h0: row_cycle_time = 4'h4;
         3'h1: row_cycle_time = 4'h4;
         3'h2: row_cycle_time = 4'h6;
         3'h3: row_cycle_time = 4'h8;
         3'h4: row_cycle_time = 4'h3;
         3'h5: row_cycle_time = 4'h5;
         default: row_cycle_time = 4'h8;
      endcase
   endfunction
endpackage

// ---- src/mir_link_if.sv ----
// command link between the memory controller and the memory
`timescale 1ns/1ps
interface mir_link_if;
   import mir_pkg::*;
   mir_cmd_type cmd;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic [1:0] output_data_strobe;

   modport ctrl (
      output cmd,
      output bank,
      output addr,
      input output_data_strobe
   );
   modport mem (
      input cmd,
      input bank,
      input addr,
      output output_data_strobe
   );
endinterface

// ---- src/mir_mem.sv ----
// memory end: follows the init sequence, captures mode, drives strobes
`timescale 1ns/1ps
module mir_mem #(
   parameter int DQ_WIDTH = mir_pkg::DQ_WIDTH_MAX
) (
   // clock and power-up reset
   input wire logic clk_sys,
   input wire logic reset,
   // command link
   mir_link_if.mem link,
   // status
   output logic mem_ready,
   output logic seq_error,
   output logic [mir_pkg::ADDR_W-1:0] mode_cfg,
   output logic [DQ_WIDTH-1:0] lane_on_second
);
   import mir_pkg::*;

   typedef enum logic [1:0] {dv_pwr, dv_load, dv_init, dv_ready} mir_dv_type;

   mir_dv_type state_ff;
   logic [3:0] load_cnt_ff;
   logic [10:0] nop_cnt_ff;
   logic [NUM_BANKS-1:0] ref_done_ff;
   logic [ADDR_W-1:0] mode_ff;
   logic err_ff;
   logic [2:0] rec_ff;
   logic [1:0] strobe_ff;
   logic is_load;
   logic group_ok;
   logic in_init;
   logic init_complete;

   assign is_load = link.cmd == cmd_mode_register_load;
   assign group_ok = load_cnt_ff >= 4'(MIN_LOADS);
   // the first command after a long enough load group already counts
   assign in_init = state_ff == dv_init ||
      (state_ff == dv_load && !is_load && group_ok);
   assign init_complete = nop_cnt_ff == 11'(INIT_NOPS) &&
      &ref_done_ff;

   // loads back to back need no recovery spacing
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_ff <= dv_pwr;
      end else begin
         case (state_ff)
            dv_pwr: if (is_load) state_ff <= dv_load;
            dv_load: begin
               if (!is_load) begin
                  state_ff <= group_ok ? dv_init : dv_pwr;
               end
            end
            // ready only after the complete sequence
            dv_init: if (init_complete) state_ff <= dv_ready;
            dv_ready: state_ff <= dv_ready;
            default: state_ff <= dv_pwr;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         load_cnt_ff <= 4'h0;
      end else if (is_load && state_ff != dv_ready) begin
         if (load_cnt_ff != 4'hf) load_cnt_ff <= load_cnt_ff + 4'h1;
      end else begin
         load_cnt_ff <= 4'h0;
      end
   end

   // the last load of the group wins, later loads reprogram
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mode_ff <= MODE_RESET;
      end else if (is_load) begin
         mode_ff <= link.addr;
      end
   end

   // commands inside the load recovery do not count toward the tail,
   // so a short tail cannot make the part ready early
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rec_ff <= 3'h0;
      end else if (is_load) begin
         rec_ff <= 3'(MRSC_CYCLES - 1);
      end else if (rec_ff != 3'h0) begin
         rec_ff <= rec_ff - 3'h1;
      end
   end

   // refreshes may fall anywhere among the nops
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         nop_cnt_ff <= 11'h000;
         ref_done_ff <= '0;
      end else if (in_init && rec_ff == 3'h0) begin
         if (link.cmd == cmd_nop && nop_cnt_ff != 11'(INIT_NOPS)) begin
            nop_cnt_ff <= nop_cnt_ff + 11'h001;
         end
         if (link.cmd == cmd_bank_refresh_cmd) begin
            ref_done_ff[link.bank] <= 1'b1;
         end
      end
   end

   // sticky: any access out of sequence leaves the part undefined
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         err_ff <= 1'b0;
      end else begin
         case (state_ff)
            dv_pwr: if (link.cmd != cmd_nop && !is_load) err_ff <= 1'b1;
            dv_load: if (!is_load && !group_ok) err_ff <= 1'b1;
            default: ;
         endcase
         if (in_init && link.cmd != cmd_nop &&
            link.cmd != cmd_bank_refresh_cmd) err_ff <= 1'b1;
      end
   end

   // strobes run once ready; the second one only on wide parts
   always_ff @(posedge clk_sys) begin
      if (reset || state_ff != dv_ready) begin
         strobe_ff <= 2'h0;
      end else begin
         strobe_ff[0] <= ~strobe_ff[0];
         strobe_ff[1] <= DQ_WIDTH > 9 ? ~strobe_ff[1] : 1'b0;
      end
   end

   // on wide parts lower half of the lanes on strobe 0, upper on strobe 1; on narrow parts all on strobe 0
   always_comb begin
      for (int i = 0; i < DQ_WIDTH; i++) begin
         lane_on_second[i] = DQ_WIDTH > 9 && i >= DQ_WIDTH / 2;
      end
   end

   assign link.output_data_strobe = strobe_ff;
   assign mem_ready = state_ff == dv_ready;
   assign seq_error = err_ff;
   assign mode_cfg = mode_ff;
endmodule

// ---- src/mir_ctrl.sv ----
// controller end: power-up sequence, refresh scheduling, user commands
`timescale 1ns/1ps
module mir_ctrl #(
   parameter int HOLD_CYCLES = mir_pkg::HOLD_CYCLES,
   parameter int DUMMY_LOADS = mir_pkg::DUMMY_LOADS,
   parameter bit REF_BURST = 1'b0
) (
   // clock and reset; clk_sys must not change rate
   input wire logic clk_sys,
   input wire logic reset,
   // command link
   mir_link_if.ctrl link,
   // user requests
   input wire logic req_valid,
   input wire mir_pkg::mir_cmd_type req_cmd,
   input wire logic [mir_pkg::BANK_W-1:0] req_bank,
   input wire logic [mir_pkg::ADDR_W-1:0] req_addr,
   output logic req_ready,
   // configuration and status
   input wire logic [mir_pkg::ADDR_W-1:0] init_cfg,
   output logic init_done
);
   import mir_pkg::*;

   typedef enum logic [2:0] {
      st_hold, st_dummy, st_valid, st_mrsc, st_init, st_run
   } mir_state_type;

   localparam int REF_PERIOD = REF_BURST ? BURST_CYCLES : REFI_CYCLES;

   mir_state_type state_ff;
   logic [31:0] wait_ff;
   logic [10:0] nop_cnt_ff;
   logic [NUM_BANKS-1:0] ref_done_ff;
   logic [3:0] trc_ff [NUM_BANKS];
   logic [ADDR_W-1:0] mode_ff;
   logic [2:0] mrsc_ff;
   logic [7:0] ref_tmr_ff;
   logic ref_pend_ff;
   logic [BANK_W-1:0] ref_bank_ff;
   logic burst_ff;
   mir_cmd_type cmd_ff;
   logic [BANK_W-1:0] bank_ff;
   logic [ADDR_W-1:0] addr_ff;
   mir_cmd_type nxt_cmd;
   logic [BANK_W-1:0] nxt_bank;
   logic [ADDR_W-1:0] nxt_addr;
   logic [NUM_BANKS-1:0] bank_idle;
   logic [BANK_W-1:0] init_bank;
   logic init_ref_ok;
   logic ref_fire;
   logic ref_set;

   always_comb begin
      for (int i = 0; i < NUM_BANKS; i++) begin
         bank_idle[i] = trc_ff[i] == 4'h0;
      end
   end

   // lowest bank still owing its initial refresh
   always_comb begin
      init_bank = '0;
      init_ref_ok = 1'b0;
      for (int i = NUM_BANKS - 1; i >= 0; i--) begin
         if (!ref_done_ff[i]) begin
            init_bank = BANK_W'(i);
            init_ref_ok = 1'b1;
         end
      end
   end

   // command choice for the next clock
   always_comb begin
      nxt_cmd = cmd_nop;
      nxt_bank = '0;
      nxt_addr = '0;
      req_ready = 1'b0;
      ref_fire = 1'b0;
      case (state_ff)
         // only nops while the supplies settle
         st_hold: nxt_cmd = cmd_nop;
         // dummy loads with a low address
         st_dummy: nxt_cmd = cmd_mode_register_load;
         st_valid: begin
            nxt_cmd = cmd_mode_register_load;
            nxt_addr = init_cfg;
         end
         st_mrsc: nxt_cmd = cmd_nop;
         // one refresh after each nop until all banks are done
         st_init: begin
            if (init_ref_ok && cmd_ff == cmd_nop) begin
               nxt_cmd = cmd_bank_refresh_cmd;
               nxt_bank = init_bank;
            end
         end
         st_run: begin
            if (mrsc_ff != 3'h0) begin
               // recovery after a later mode load
               nxt_cmd = cmd_nop;
            end else if (burst_ff || (REF_BURST && ref_pend_ff &&
               &bank_idle)) begin
               // eight refreshes back to back
               nxt_cmd = cmd_bank_refresh_cmd;
               nxt_bank = ref_bank_ff;
               ref_fire = 1'b1;
            end else if (!REF_BURST && ref_pend_ff) begin
               // refresh first; wait for its bank to be idle
               if (bank_idle[ref_bank_ff]) begin
                  nxt_cmd = cmd_bank_refresh_cmd;
                  nxt_bank = ref_bank_ff;
                  ref_fire = 1'b1;
               end
            end else if (req_valid) begin
               case (req_cmd)
                  cmd_read, cmd_write: begin
                     // bank busy for the row cycle time
                     req_ready = bank_idle[req_bank];
                     if (req_ready) nxt_cmd = req_cmd;
                  end
                  // only with every bank idle
                  cmd_mode_register_load: begin
                     req_ready = &bank_idle;
                     if (req_ready) nxt_cmd = req_cmd;
                  end
                  default: req_ready = 1'b1;
               endcase
               nxt_bank = req_bank;
               nxt_addr = req_addr;
            end
         end
         default: nxt_cmd = cmd_nop;
      endcase
   end

   // sequence state and its wait counter
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_ff <= st_hold;
         wait_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= wait_ff + 32'h0000_0001;
         case (state_ff)
            // stable nops for the full hold time
            st_hold: begin
               if (wait_ff >= 32'(HOLD_CYCLES - 1)) begin
                  state_ff <= st_dummy;
                  wait_ff <= 32'h0000_0000;
               end
            end
            // dummy loads then the valid one, no gap
            st_dummy: begin
               if (wait_ff >= 32'(DUMMY_LOADS - 1)) begin
                  state_ff <= st_valid;
               end
            end
            st_valid: begin
               state_ff <= st_mrsc;
               wait_ff <= 32'h0000_0000;
            end
            // recovery only after the valid load
            st_mrsc: begin
               if (wait_ff >= 32'(MRSC_CYCLES - 1)) state_ff <= st_init;
            end
            // release traffic on full count and all flags
            st_init: begin
               if (nop_cnt_ff == 11'(INIT_NOPS) && &ref_done_ff &&
                  cmd_ff == cmd_nop) begin
                  state_ff <= st_run;
               end
            end
            st_run: state_ff <= st_run;
            default: state_ff <= st_hold;
         endcase
      end
   end

   // init nop count and per-bank refresh flags
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         nop_cnt_ff <= 11'h000;
         ref_done_ff <= '0;
      end else if (state_ff == st_init) begin
         if (nxt_cmd == cmd_nop && nop_cnt_ff != 11'(INIT_NOPS)) begin
            nop_cnt_ff <= nop_cnt_ff + 11'h001;
         end
         if (nxt_cmd == cmd_bank_refresh_cmd) begin
            ref_done_ff[nxt_bank] <= 1'b1;
         end
      end
   end

   // per-bank row cycle timers, loaded as a command leaves
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < NUM_BANKS; i++) trc_ff[i] <= 4'h0;
      end else begin
         for (int i = 0; i < NUM_BANKS; i++) begin
            if (trc_ff[i] != 4'h0) trc_ff[i] <= trc_ff[i] - 4'h1;
         end
         if (nxt_cmd == cmd_bank_refresh_cmd || nxt_cmd == cmd_read ||
            nxt_cmd == cmd_write) begin
            trc_ff[nxt_bank] <= row_cycle_time(mode_ff) - 4'h1;
         end
      end
   end

   // mode copy sets the row cycle time
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mode_ff <= MODE_RESET;
         mrsc_ff <= 3'h0;
      end else begin
         if (mrsc_ff != 3'h0) mrsc_ff <= mrsc_ff - 3'h1;
         if (nxt_cmd == cmd_mode_register_load) begin
            if (state_ff == st_valid || state_ff == st_run) begin
               mode_ff <= nxt_addr;
            end
            if (state_ff == st_run) mrsc_ff <= 3'(MRSC_CYCLES - 1);
         end
      end
   end

   // free-running refresh timer; a new tick wins over the clear
   assign ref_set = state_ff == st_run && ref_tmr_ff == 8'h00;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ref_tmr_ff <= 8'(REF_PERIOD - 1);
         ref_pend_ff <= 1'b0;
      end else begin
         if (state_ff == st_run) begin
            ref_tmr_ff <= ref_set ? 8'(REF_PERIOD - 1) : ref_tmr_ff - 8'h01;
         end
         ref_pend_ff <= ref_set || (ref_pend_ff && !(ref_fire &&
            (!REF_BURST || !burst_ff)));
      end
   end

   // bank rotation and burst tracking
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ref_bank_ff <= '0;
         burst_ff <= 1'b0;
      end else if (ref_fire) begin
         ref_bank_ff <= ref_bank_ff + BANK_W'(1);
         burst_ff <= REF_BURST && ref_bank_ff != BANK_W'(NUM_BANKS - 1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_ff <= cmd_nop;
         bank_ff <= '0;
         addr_ff <= '0;
      end else begin
         cmd_ff <= nxt_cmd;
         bank_ff <= nxt_bank;
         addr_ff <= nxt_addr;
      end
   end

   assign link.cmd = cmd_ff;
   assign link.bank = bank_ff;
   assign link.addr = addr_ff;
   assign init_done = state_ff == st_run;
endmodule

// ---- testbench/mir_link_chk.sv ----
// assertions on the command link between the two ends
`timescale 1ns/1ps
module mir_link_chk #(
   parameter int HOLD_CYCLES = mir_pkg::HOLD_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // command link
   input wire mir_pkg::mir_cmd_type cmd,
   input wire logic [mir_pkg::BANK_W-1:0] bank,
   input wire logic [mir_pkg::ADDR_W-1:0] addr,
   input wire logic [1:0] output_data_strobe
);
   import mir_pkg::*;
   logic [15:0] cyc_ff;
   logic group_ff;
   logic run_ff;
   logic [10:0] nops_ff;
   logic [7:0] refd_ff;
   logic [7:0] gap_ff;
   wire logic is_load = cmd == cmd_mode_register_load;
   wire logic is_ref = cmd == cmd_bank_refresh_cmd;
   wire logic is_acc = cmd == cmd_read || cmd == cmd_write;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cyc_ff <= 16'h0000;
      end else if (cyc_ff != 16'hffff) begin
         cyc_ff <= cyc_ff + 16'h0001;
      end
   end
   // init tail bookkeeping: nops after the load group and banks refreshed
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         group_ff <= 1'b0;
         nops_ff <= 11'h000;
         refd_ff <= 8'h00;
      end else begin
         group_ff <= group_ff | is_load;
         if (group_ff && cmd == cmd_nop && nops_ff != 11'h400) begin
            nops_ff <= nops_ff + 11'h001;
         end
         if (group_ff && is_ref) begin
            refd_ff <= refd_ff | (8'h01 << bank);
         end
      end
   end
   // cycles since the last refresh once strobes run
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         run_ff <= 1'b0;
         gap_ff <= 8'h00;
      end else begin
         run_ff <= run_ff | (output_data_strobe != 2'h0);
         if (is_ref) begin
            gap_ff <= 8'h00;
         end else if (run_ff && gap_ff != 8'hff) begin
            gap_ff <= gap_ff + 8'h01;
         end
      end
   end

   chk_hold_nops: assert property (
      cyc_ff < 16'(HOLD_CYCLES) |-> cmd == cmd_nop)
      else $error("command issued during the power-up hold");
   chk_load_group: assert property (
      $rose(is_load) && !group_ff |-> is_load [*3] ##1 cmd == cmd_nop)
      else $error("init load group not three consecutive loads");
   chk_dummy_addr: assert property (
      $rose(is_load) && !group_ff |-> addr == '0 ##1 addr == '0)
      else $error("dummy load with address not low");
   chk_load_recovery: assert property (
      $fell(is_load) |-> (cmd == cmd_nop) [*5])
      else $error("command inside mode load recovery");
   chk_tail_access: assert property (
      is_acc |-> nops_ff == 11'h400 && refd_ff == 8'hff)
      else $error("access before init tail complete");
   chk_ready_after_tail: assert property (
      run_ff |-> nops_ff == 11'h400 && refd_ff == 8'hff)
      else $error("strobes running before init complete");
   chk_refresh_rowtime: assert property (
      is_ref |=> !(cmd != cmd_nop && bank == $past(bank))
      ##1 !(cmd != cmd_nop && bank == $past(bank, 2)))
      else $error("same bank used too soon after refresh");
   chk_refresh_gap: assert property (
      run_ff |-> gap_ff <= 8'd60)
      else $error("refresh interval too long");
   chk_strobe_toggle: assert property (
      run_ff |=> output_data_strobe == ~$past(output_data_strobe))
      else $error("output strobe not toggling");

   cov_group: cover property ($rose(is_load) && !group_ff);
   cov_run_load: cover property (run_ff && is_load);
   cov_access: cover property (run_ff && is_acc);
   cov_refresh: cover property (run_ff && is_ref);
endmodule

// ---- testbench/mir_memory_init_refresh_sequence_bench.sv ----
// self-checking bench: both link ends plus a rule-breaking second link
`timescale 1ns/1ps
module mir_memory_init_refresh_sequence_bench;
   import mir_pkg::*;
   localparam int HOLD = 20;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic reset_b = 1'b1;
   logic req_valid, req_ready, init_done;
   mir_cmd_type req_cmd;
   logic [BANK_W-1:0] req_bank;
   logic [ADDR_W-1:0] req_addr, init_cfg, mode_cfg, mode_cfg_b;
   logic mem_ready, seq_error, mem_ready_b, seq_error_b;
   logic mem_ready_c, seq_error_c, req_valid_c;
   logic [35:0] lane_on_second;
   logic [17:0] lane_on_second_c;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int last_use [8] = '{default: 0};
   int min_gap = 1000;
   int n_rw = 0;
   int n_ref = 0;

   always #4 clk_sys = ~clk_sys;

   mir_link_if i_link();
   mir_link_if i_link_b();
   mir_ctrl #(.HOLD_CYCLES(HOLD)) i_mir_ctrl (.clk_sys(clk_sys),
      .reset(reset), .link(i_link.ctrl), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
      .req_ready(req_ready), .init_cfg(init_cfg), .init_done(init_done));
   mir_mem i_mir_mem (.clk_sys(clk_sys), .reset(reset),
      .link(i_link.mem), .mem_ready(mem_ready), .seq_error(seq_error),
      .mode_cfg(mode_cfg), .lane_on_second(lane_on_second));
   mir_mem i_mir_mem_b (.clk_sys(clk_sys), .reset(reset_b),
      .link(i_link_b.mem), .mem_ready(mem_ready_b),
      .seq_error(seq_error_b), .mode_cfg(mode_cfg_b), .lane_on_second());
   // burst-refresh controller with a narrower memory on its own link
   mir_link_if i_link_c();
   mir_ctrl #(.HOLD_CYCLES(HOLD), .REF_BURST(1'b1)) i_mir_ctrl_b (
      .clk_sys(clk_sys), .reset(reset), .link(i_link_c.ctrl),
      .req_valid(req_valid_c), .req_cmd(req_cmd), .req_bank(req_bank),
      .req_addr(req_addr), .req_ready(), .init_cfg(init_cfg),
      .init_done());
   mir_mem #(.DQ_WIDTH(18)) i_mir_mem_c (.clk_sys(clk_sys),
      .reset(reset), .link(i_link_c.mem), .mem_ready(mem_ready_c),
      .seq_error(seq_error_c), .mode_cfg(),
      .lane_on_second(lane_on_second_c));
   mir_link_chk #(.HOLD_CYCLES(HOLD)) i_mir_link_chk (.clk_sys(clk_sys),
      .reset(reset), .cmd(i_link.cmd), .bank(i_link.bank),
      .addr(i_link.addr), .output_data_strobe(i_link.output_data_strobe));

   // link monitor: spacing per bank and command counts
   always @(posedge clk_sys) begin
      cyc++;
      if (i_link.cmd === cmd_read || i_link.cmd === cmd_write) begin
         n_rw++;
      end
      if (i_link.cmd === cmd_bank_refresh_cmd) begin
         n_ref++;
      end
      if (!reset && i_link.cmd !== cmd_nop &&
         i_link.cmd !== cmd_mode_register_load) begin
         if (cyc - last_use[i_link.bank] < min_gap) begin
            min_gap = cyc - last_use[i_link.bank];
         end
         last_use[i_link.bank] = cyc;
      end
   end

   task automatic cmp_vec(string what, logic [35:0] exp, logic [35:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_flag(string what, logic exp, logic got);
      cmp_vec(what, {35'h0, exp}, {35'h0, got});
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic req(mir_cmd_type c, logic [2:0] b, logic [17:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_bank <= b;
      req_addr <= a;
      @(posedge clk_sys);
      while (req_ready !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      cmp_flag("req_ready", 1'b1, req_ready);
      req_valid <= 1'b0;
   endtask
   task automatic drv(mir_cmd_type c, logic [2:0] b, logic [17:0] a, int n);
      repeat (n) begin
         @(posedge clk_sys);
         i_link_b.cmd <= c;
         i_link_b.bank <= b;
         i_link_b.addr <= a;
      end
   endtask
   task automatic rst_b;
      drv(cmd_nop, 3'h0, 18'h00000, 1);
      reset_b <= 1'b1;
      @(posedge clk_sys);
      reset_b <= 1'b0;
      drv(cmd_nop, 3'h0, 18'h00000, 3);
   endtask

   task automatic t_power_up;
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (2) @(posedge clk_sys);
      cmp_flag("init_done", 1'b1, init_done);
      cmp_flag("init span", 1'b1, n >= HOLD + 1032);
      cmp_flag("mem_ready", 1'b1, mem_ready);
      cmp_flag("seq_error", 1'b0, seq_error);
      cmp_vec("mode_cfg", 36'(init_cfg), 36'(mode_cfg));
      cmp_vec("lane_on_second", 36'hffffc0000, lane_on_second);
      $display("power-up test done");
   endtask
   task automatic t_traffic;
      n_rw = 0;
      for (int i = 0; i < 40; i++) begin
         req(i[0] ? cmd_write : cmd_read, 3'(i / 3), 18'(i));
      end
      repeat (12) @(posedge clk_sys);
      cmp_vec("accesses", 36'd40, 36'(n_rw));
      cmp_flag("row spacing", 1'b1, min_gap >= 8);
      $display("traffic test done");
   endtask
   task automatic t_mode_load;
      req(cmd_mode_register_load, 3'h0, 18'h00002);
      repeat (10) @(posedge clk_sys);
      cmp_vec("mode_cfg", 36'h00002, 36'(mode_cfg));
      cmp_flag("seq_error", 1'b0, seq_error);
      $display("mode load test done");
   endtask
   task automatic t_refresh;
      n_ref = 0;
      repeat (600) @(posedge clk_sys);
      cmp_flag("refresh rate", 1'b1, n_ref >= 19 && n_ref <= 21);
      $display("refresh test done");
   endtask
   task automatic t_refresh_burst;
      int n;
      logic hit;
      n = 0;
      while (i_link_c.cmd === cmd_bank_refresh_cmd) @(posedge clk_sys);
      while (i_link_c.cmd !== cmd_bank_refresh_cmd && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      for (int b = 0; b < 8; b++) begin
         hit = i_link_c.cmd === cmd_bank_refresh_cmd;
         cmp_flag("burst cmd", 1'b1, hit);
         cmp_vec("burst bank", 36'(b), 36'(i_link_c.bank));
         @(posedge clk_sys);
      end
      n = 0;
      while (i_link_c.cmd !== cmd_bank_refresh_cmd && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
      cmp_vec("burst period", 36'(BURST_CYCLES - 8), 36'(n));
      cmp_flag("mem_ready_c", 1'b1, mem_ready_c);
      cmp_flag("seq_error_c", 1'b0, seq_error_c);
      cmp_vec("lanes_c", 36'h3fe00, 36'(lane_on_second_c));
      $display("burst refresh test done");
   endtask
   task automatic t_early_access;
      rst_b();
      drv(cmd_read, 3'h1, 18'h00000, 1);
      drv(cmd_nop, 3'h0, 18'h00000, 2);
      cmp_flag("seq_error_b", 1'b1, seq_error_b);
      $display("early access test done");
   endtask
   task automatic t_short_group;
      rst_b();
      drv(cmd_mode_register_load, 3'h0, 18'h00000, 2);
      drv(cmd_nop, 3'h0, 18'h00000, 3);
      cmp_flag("seq_error_b", 1'b1, seq_error_b);
      $display("short group test done");
   endtask
   task automatic t_tail_access;
      rst_b();
      drv(cmd_mode_register_load, 3'h0, 18'h00000, 3);
      drv(cmd_nop, 3'h0, 18'h00000, 6);
      drv(cmd_write, 3'h2, 18'h00000, 1);
      drv(cmd_nop, 3'h0, 18'h00000, 2);
      cmp_flag("seq_error_b", 1'b1, seq_error_b);
      $display("tail access test done");
   endtask
   task automatic t_burst_init;
      rst_b();
      // four loads, dummies not low: last address must win
      drv(cmd_mode_register_load, 3'h0, 18'h00007, 3);
      drv(cmd_mode_register_load, 3'h0, 18'h00005, 1);
      drv(cmd_nop, 3'h0, 18'h00000, 6);
      for (int b = 0; b < 8; b++) begin
         drv(cmd_bank_refresh_cmd, 3'(b), 18'h00000, 1);
      end
      drv(cmd_nop, 3'h0, 18'h00000, 1030);
      cmp_flag("mem_ready_b", 1'b1, mem_ready_b);
      cmp_flag("seq_error_b", 1'b0, seq_error_b);
      cmp_vec("mode_cfg_b", 36'h00005, 36'(mode_cfg_b));
      $display("burst init test done");
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      wrap_up();
   end

   initial begin
      req_valid = 1'b0;
      req_valid_c = 1'b0;
      req_cmd = cmd_nop;
      req_bank = 3'h0;
      req_addr = 18'h00000;
      init_cfg = 18'h00003;
      i_link_b.cmd = cmd_nop;
      i_link_b.bank = 3'h0;
      i_link_b.addr = 18'h00000;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      reset_b <= 1'b0;
      t_power_up();
      t_traffic();
      t_mode_load();
      t_refresh();
      t_refresh_burst();
      t_early_access();
      t_short_group();
      t_tail_access();
      t_burst_init();
      wrap_up();
   end
endmodule
